// [rtl/msio_defs.svh]
`ifndef MSIO_DEFS_SVH
`define MSIO_DEFS_SVH

// Clock rate, documented times and skipped-point limit.
`define MSIO_CLK_KHZ 25000
`define MSIO_T_CLEAR_US 5000
`define MSIO_T_OPEN_US 1500
`define MSIO_T_JUDGE_MS 50
`define MSIO_T_DONE_MS 30
`define MSIO_T_BEAT_MS 500
`define MSIO_SKIP_LIMIT 10

// Register byte offsets.
`define MSIO_ADDR_CTRL 4'h0
`define MSIO_ADDR_PRESET 4'h4
`define MSIO_ADDR_STATUS 4'h8
`define MSIO_ADDR_CARD 4'hC

// Control and card register fields.
`define MSIO_CTRL_LEVEL 0
`define MSIO_CTRL_SECT_EXT 1
`define MSIO_CTRL_RELATIVE 2
`define MSIO_CTRL_SECT_LO 4
`define MSIO_CTRL_SECT_HI 7
`define MSIO_CARD_CLR 0

// Synchronised input vector positions.
`define MSIO_IN_ZERO 0
`define MSIO_IN_PRESET 1
`define MSIO_IN_START 2
`define MSIO_IN_STOP 3
`define MSIO_IN_SECT 4
`define MSIO_IN_RESET 5
`define MSIO_IN_LOCK 6
`define MSIO_IN_LIGHT 7
`define MSIO_IN_COUNT 8

`endif

// [rtl/msio_pkg.sv]
package msio_pkg;

	typedef enum logic [2:0] {
		msio_await_start,
		msio_await_release,
		msio_open_wait,
		msio_await_level,
		msio_sampling,
		msio_judge_wait,
		msio_done_wait
	} msio_state_t;

endpackage : msio_pkg

// [rtl/msio_top.sv]
`timescale 1ns/1ps
`include "msio_defs.svh"

module msio_top #(
	parameter int unsigned DATA_W = 16,
	parameter int unsigned SECT_W = 4,
	parameter int unsigned CNT_W = 24,
	parameter int unsigned T_CLEAR =
		`MSIO_T_CLEAR_US * `MSIO_CLK_KHZ / 1000,
	parameter int unsigned T_OPEN =
		`MSIO_T_OPEN_US * `MSIO_CLK_KHZ / 1000,
	parameter int unsigned T_JUDGE = `MSIO_T_JUDGE_MS * `MSIO_CLK_KHZ,
	parameter int unsigned T_DONE = `MSIO_T_DONE_MS * `MSIO_CLK_KHZ,
	parameter int unsigned T_BEAT = `MSIO_T_BEAT_MS * `MSIO_CLK_KHZ
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset,
	// Controller inputs.
	input wire logic zero_req,
	input wire logic displacement_preset,
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic section_adv,
	input wire logic reset_in,
	input wire logic panel_lock,
	input wire logic backlight_in,
	// Measurement engine conditions.
	input wire logic [DATA_W-1:0] load_value,
	input wire logic disp_pulse,
	input wire logic level_crossed,
	input wire logic stop_cond,
	input wire logic hold_done,
	input wire logic peak_judged,
	input wire logic peak_low_hit,
	input wire logic peak_high_hit,
	input wire logic profile_low_hit,
	input wire logic profile_high_hit,
	input wire logic area_passed,
	input wire logic rel_ref_reached,
	input wire logic point_skipped,
	input wire logic sensor_error,
	input wire logic overrange,
	input wire logic overload_cond,
	input wire logic zero_over_limit,
	input wire logic card_error,
	input wire logic autosave_busy,
	input wire logic panel_edit_req,
	// Controller outputs.
	output logic peak_low,
	output logic peak_pass,
	output logic peak_high,
	output logic profile_low,
	output logic profile_pass,
	output logic profile_high,
	output logic complete,
	output logic overload,
	output logic load_healthy,
	output logic displacement_healthy,
	output logic card_healthy,
	output logic heartbeat,
	// Engine and panel outputs.
	output logic [DATA_W-1:0] zero_offset,
	output logic [DATA_W-1:0] displacement,
	output logic [SECT_W-1:0] hold_section,
	output logic sampling,
	output logic discard,
	output logic panel_edit_ok,
	output logic backlight,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	function automatic logic [CNT_W-1:0] ticks(input int unsigned n);
		ticks = (n > 1) ? CNT_W'(n - 1) : '0;
	endfunction : ticks

	logic [`MSIO_IN_COUNT-1:0] raw;
	logic [`MSIO_IN_COUNT-1:0] sync1_q;
	logic [`MSIO_IN_COUNT-1:0] sync2_q;
	logic [`MSIO_IN_COUNT-1:0] prev_q;
	logic [`MSIO_IN_COUNT-1:0] rise;
	logic [`MSIO_IN_COUNT-1:0] fall;
	logic [`MSIO_IN_COUNT-1:0] lvl;

	msio_pkg::msio_state_t state_q;
	logic [CNT_W-1:0] timer_q;
	logic [CNT_W-1:0] beat_q;
	logic timer_done;
	logic start_ok;
	logic stop_now;
	logic cleanup_q;
	logic [7:0] ctrl_q;
	logic [DATA_W-1:0] preset_q;
	logic [DATA_W-1:0] pulse_cnt_q;
	logic [SECT_W-1:0] holds_q;
	logic [SECT_W-1:0] sect_cfg;
	logic judged_q;
	logic area_q;
	logic ref_q;
	logic [3:0] skip_q;
	logic skip_flag;
	logic card_err_q;
	logic late_save_q;
	logic card_clr;

	assign raw = {backlight_in, panel_lock, reset_in, section_adv,
		stop_in, start_in, displacement_preset, zero_req};

	// Two-stage synchroniser, edges from stage two against stage three.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	assign lvl = sync2_q;
	assign rise = sync2_q & ~prev_q;
	assign fall = ~sync2_q & prev_q;

	assign sect_cfg = ctrl_q[`MSIO_CTRL_SECT_HI:`MSIO_CTRL_SECT_LO];
	assign card_clr = reg_wr && reg_addr == `MSIO_ADDR_CARD &&
		reg_wdata[`MSIO_CARD_CLR];
	assign timer_done = timer_q == '0;
	assign start_ok = rise[`MSIO_IN_START] && !autosave_busy;
	assign stop_now = rise[`MSIO_IN_STOP] || stop_cond;
	assign sampling = state_q == msio_pkg::msio_sampling;
	assign discard = rise[`MSIO_IN_RESET] && sampling;

	// Measurement sequence.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= msio_pkg::msio_await_start;
			timer_q <= '0;
		end else if (rise[`MSIO_IN_RESET]) begin
			state_q <= msio_pkg::msio_await_start;
			timer_q <= '0;
		end else begin
			if (!timer_done)
				timer_q <= timer_q - 1'b1;
			unique case (state_q)
			msio_pkg::msio_await_start: begin
				if (start_ok) begin
					state_q <= msio_pkg::msio_await_release;
					timer_q <= ticks(T_CLEAR);
				end
			end
			msio_pkg::msio_await_release: begin
				if (fall[`MSIO_IN_START]) begin
					state_q <= msio_pkg::msio_open_wait;
					timer_q <= ticks(T_OPEN);
				end
			end
			msio_pkg::msio_open_wait: begin
				if (timer_done) begin
					if (ctrl_q[`MSIO_CTRL_LEVEL])
						state_q <= msio_pkg::msio_await_level;
					else
						state_q <= msio_pkg::msio_sampling;
				end
			end
			msio_pkg::msio_await_level: begin
				if (level_crossed)
					state_q <= msio_pkg::msio_sampling;
			end
			msio_pkg::msio_sampling: begin
				if (stop_now) begin
					state_q <= msio_pkg::msio_judge_wait;
					timer_q <= ticks(T_JUDGE);
				end
			end
			msio_pkg::msio_judge_wait: begin
				if (timer_done) begin
					state_q <= msio_pkg::msio_done_wait;
					timer_q <= ticks(T_DONE);
				end
			end
			msio_pkg::msio_done_wait: begin
				if (timer_done)
					state_q <= msio_pkg::msio_await_start;
			end
			endcase
		end
	end

	// Pending output clear after an accepted start.
	always_ff @(posedge sys_clk) begin
		if (reset)
			cleanup_q <= 1'b0;
		else if (start_ok)
			cleanup_q <= 1'b1;
		else if (state_q != msio_pkg::msio_await_release || timer_done)
			cleanup_q <= 1'b0;
	end

	// Judgment latches and pass evaluation.
	always_ff @(posedge sys_clk) begin
		if (reset || rise[`MSIO_IN_RESET] || start_ok) begin
			peak_low <= 1'b0;
			peak_high <= 1'b0;
			profile_low <= 1'b0;
			profile_high <= 1'b0;
			peak_pass <= 1'b0;
			profile_pass <= 1'b0;
		end else if (sampling) begin
			peak_low <= peak_low | peak_low_hit;
			peak_high <= peak_high | peak_high_hit;
			profile_low <= profile_low | profile_low_hit;
			profile_high <= profile_high | profile_high_hit;
		end else if (state_q == msio_pkg::msio_judge_wait &&
			timer_done) begin
			// A failing result leaves the pass line off; the low and high latches keep their values.
			peak_pass <= judged_q && !peak_low && !peak_high &&
				holds_q >= sect_cfg;
			profile_pass <= area_q && !profile_low && !profile_high &&
				(!ctrl_q[`MSIO_CTRL_RELATIVE] || ref_q);
		end
	end

	// Evidence gathered during sampling for the pass outputs.
	always_ff @(posedge sys_clk) begin
		if (reset || start_ok || discard) begin
			judged_q <= 1'b0;
			area_q <= 1'b0;
			ref_q <= 1'b0;
			holds_q <= '0;
		end else if (sampling) begin
			judged_q <= judged_q | peak_judged;
			area_q <= area_q | area_passed;
			ref_q <= ref_q | rel_ref_reached;
			if (hold_done && holds_q != '1)
				holds_q <= holds_q + 1'b1;
		end
	end

	// Hold section selection.
	always_ff @(posedge sys_clk) begin
		if (reset || start_ok || rise[`MSIO_IN_RESET])
			hold_section <= '0;
		else if (ctrl_q[`MSIO_CTRL_SECT_EXT] && rise[`MSIO_IN_SECT] &&
			hold_section != '1)
			hold_section <= hold_section + 1'b1;
	end

	// Complete flag.
	always_ff @(posedge sys_clk) begin
		if (reset || start_ok || rise[`MSIO_IN_RESET])
			complete <= 1'b0;
		else if (state_q == msio_pkg::msio_done_wait && timer_done)
			complete <= 1'b1;
	end

	// Load zeroing.
	always_ff @(posedge sys_clk) begin
		if (reset)
			zero_offset <= '0;
		else if (rise[`MSIO_IN_ZERO])
			zero_offset <= load_value;
	end

	// Displacement preset and pulse counting.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pulse_cnt_q <= '0;
			displacement <= '0;
		end else if (rise[`MSIO_IN_PRESET]) begin
			pulse_cnt_q <= '0;
			displacement <= preset_q;
		end else if (disp_pulse) begin
			pulse_cnt_q <= pulse_cnt_q + 1'b1;
			displacement <= displacement + 1'b1;
		end
	end

	// Skipped-point count per measurement.
	always_ff @(posedge sys_clk) begin
		if (reset || start_ok || rise[`MSIO_IN_RESET])
			skip_q <= '0;
		else if (point_skipped && !skip_flag)
			skip_q <= skip_q + 1'b1;
	end
	assign skip_flag = skip_q >= 4'(`MSIO_SKIP_LIMIT);

	// Card status; a new error wins over a clear in the same cycle.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			card_err_q <= 1'b0;
			late_save_q <= 1'b0;
		end else begin
			card_err_q <= card_error | (card_err_q & ~card_clr);
			if (state_q == msio_pkg::msio_await_start &&
				rise[`MSIO_IN_START])
				late_save_q <= autosave_busy;
		end
	end

	// Health, overload, panel and backlight outputs.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			load_healthy <= 1'b0;
			displacement_healthy <= 1'b0;
			card_healthy <= 1'b0;
			overload <= 1'b0;
			panel_edit_ok <= 1'b0;
			backlight <= 1'b0;
		end else begin
			load_healthy <= !(sensor_error || overrange || overload_cond ||
				zero_over_limit || lvl[`MSIO_IN_START] ||
				lvl[`MSIO_IN_RESET] || lvl[`MSIO_IN_ZERO] ||
				cleanup_q);
			displacement_healthy <= !(skip_flag || lvl[`MSIO_IN_START] ||
				lvl[`MSIO_IN_RESET] || lvl[`MSIO_IN_PRESET] ||
				cleanup_q);
			card_healthy <= !(card_err_q || late_save_q ||
				lvl[`MSIO_IN_START] || lvl[`MSIO_IN_RESET]);
			overload <= overload_cond;
			panel_edit_ok <= panel_edit_req && !lvl[`MSIO_IN_LOCK];
			backlight <= rise[`MSIO_IN_LIGHT] ||
				lvl[`MSIO_IN_LIGHT];
		end
	end

	// Heartbeat.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			beat_q <= '0;
			heartbeat <= 1'b0;
		end else if (beat_q == ticks(T_BEAT)) begin
			beat_q <= '0;
			heartbeat <= ~heartbeat;
		end else begin
			beat_q <= beat_q + 1'b1;
		end
	end

	// Configuration registers.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl_q <= '0;
			preset_q <= '0;
		end else if (reg_wr) begin
			if (reg_addr == `MSIO_ADDR_CTRL)
				ctrl_q <= reg_wdata[7:0];
			if (reg_addr == `MSIO_ADDR_PRESET)
				preset_q <= reg_wdata[DATA_W-1:0];
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge sys_clk) begin
		if (reset || !reg_rd) begin
			reg_rdata <= '0;
		end else begin
			unique case (reg_addr)
			`MSIO_ADDR_CTRL: reg_rdata <= {24'h000000, ctrl_q};
			`MSIO_ADDR_PRESET: reg_rdata <= 32'(preset_q);
			`MSIO_ADDR_STATUS: reg_rdata <= {16'h0000, pulse_cnt_q[3:0],
				4'(holds_q), skip_flag, card_err_q, late_save_q,
				judged_q, 1'b0, 3'(state_q)};
			default: reg_rdata <= '0;
			endcase
		end
	end

endmodule : msio_top

// [sim/msio_checker.sv]
`timescale 1ns/1ps
module msio_checker #(
	parameter int unsigned T_BEAT = 12
) (
	// Clock, reset, controller inputs and engine conditions.
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic start_in,
	input wire logic reset_in,
	input wire logic zero_req,
	input wire logic overload_cond,
	input wire logic backlight_in,
	input wire logic panel_lock,
	input wire logic panel_edit_req,
	// Device outputs.
	input wire logic peak_low,
	input wire logic peak_pass,
	input wire logic peak_high,
	input wire logic profile_low,
	input wire logic profile_pass,
	input wire logic profile_high,
	input wire logic complete,
	input wire logic overload,
	input wire logic load_healthy,
	input wire logic displacement_healthy,
	input wire logic card_healthy,
	input wire logic heartbeat,
	input wire logic sampling,
	input wire logic discard,
	input wire logic backlight,
	input wire logic panel_edit_ok
);
	logic [4:0] hist_q;
	logic [7:0] beat_q;
	logic hb_q;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	sequence held_s(sig);
		sig [*4];
	endsequence
	// Complete, peak_low and profile_high may only fall shortly after start or reset input.
	always_ff @(posedge sys_clk) begin
		hist_q <= {hist_q[3:0], start_in | reset_in};
	end
	always_ff @(posedge sys_clk) begin
		hb_q <= heartbeat;
		beat_q <= (reset || heartbeat != hb_q) ? 8'h00 : beat_q + 8'h01;
	end
	a_overload_tracks: assert property (
		!$past(reset) |-> overload == $past(overload_cond))
		else $error("overload lags its condition");
	a_zero_unhealthy: assert property (
		held_s(zero_req) |=> !load_healthy)
		else $error("load healthy during zero");
	a_start_unhealthy: assert property (
		held_s(start_in) |=> !(load_healthy || displacement_healthy ||
		card_healthy)) else $error("healthy during start");
	a_reset_clears: assert property (
		held_s(reset_in) |=> !(peak_pass || profile_pass || load_healthy ||
		card_healthy)) else $error("outputs kept through reset input");
	a_pass_clean: assert property (
		!(peak_pass && (peak_low || peak_high)) &&
		!(profile_pass && (profile_low || profile_high)))
		else $error("pass beside a limit");
	a_clear_cause: assert property (
		$fell(complete) || $fell(peak_low) || $fell(profile_high) |->
		|hist_q) else $error("latched output fell on its own");
	a_discard_stops: assert property (
		discard |-> sampling ##1 !sampling)
		else $error("discard kept sampling");
	a_judge_delay: assert property (
		$fell(sampling) |-> !complete [*8])
		else $error("complete too early");
	a_beat_period: assert property (
		beat_q <= T_BEAT + 2) else $error("heartbeat stuck");
	a_light_follows: assert property (
		held_s(backlight_in) |=> backlight)
		else $error("backlight off while input held");
	a_lock_blocks: assert property (
		held_s(panel_lock) |=> !panel_edit_ok)
		else $error("setting change passed while locked");
	a_edit_passes: assert property (
		held_s(!panel_lock) |=> panel_edit_ok == $past(panel_edit_req))
		else $error("setting change lost while unlocked");
endmodule : msio_checker

bind msio_top msio_checker #(.T_BEAT(T_BEAT)) u_chk (.sys_clk, .reset,
	.start_in, .reset_in, .zero_req, .overload_cond, .peak_low, .peak_pass,
	.peak_high, .profile_low, .profile_pass, .profile_high, .complete,
	.overload, .load_healthy, .displacement_healthy, .card_healthy,
	.heartbeat, .sampling, .discard, .backlight_in, .panel_lock,
	.panel_edit_req, .backlight, .panel_edit_ok);

// [sim/msio_ctrl_model.sv]
`timescale 1ns/1ps
module msio_ctrl_model (
	// Device side.
	input wire logic sys_clk,
	input wire logic complete,
	input wire logic [5:0] judge,
	// Sampled result.
	output logic seen,
	output logic [5:0] res,
	output logic fail
);
	logic prev_q;
	always_ff @(posedge sys_clk) begin
		prev_q <= complete;
		seen <= complete && !prev_q;
		if (complete && !prev_q) begin
			res <= judge;
			fail <= !judge[4];
		end
	end
endmodule : msio_ctrl_model

// [sim/measurement_sequence_io_tb.sv]
`timescale 1ns/1ps
`include "msio_defs.svh"
module measurement_sequence_io_tb;
	logic sys_clk, reset, zero_req, displacement_preset, start_in, stop_in;
	logic section_adv, reset_in, panel_lock, backlight_in, disp_pulse;
	logic level_crossed, stop_cond, hold_done, peak_judged, peak_low_hit;
	logic peak_high_hit, profile_low_hit, profile_high_hit, area_passed;
	logic rel_ref_reached, point_skipped, sensor_error, overrange, seen;
	logic overload_cond, zero_over_limit, card_error, autosave_busy, fail;
	logic panel_edit_req, peak_low, peak_pass, peak_high, profile_low;
	logic profile_pass, profile_high, complete, overload, load_healthy;
	logic displacement_healthy, card_healthy, heartbeat, sampling, rdp;
	logic discard, panel_edit_ok, backlight, reg_wr, reg_rd;
	logic [15:0] load_value, zero_offset, displacement;
	logic [3:0] hold_section, reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [63:0] m;
	logic [5:0] res, j;
	logic [63:0] rq[$];
	logic [5:0] jq[$];
	int n_mismatch, num_checks, k;
	bit rel;

	msio_top #(.T_CLEAR(8), .T_OPEN(6), .T_JUDGE(10), .T_DONE(5),
		.T_BEAT(12)) dut (.sys_clk, .reset, .zero_req, .displacement_preset,
		.start_in, .stop_in, .section_adv, .reset_in, .panel_lock,
		.backlight_in, .load_value, .disp_pulse, .level_crossed, .stop_cond,
		.hold_done, .peak_judged, .peak_low_hit, .peak_high_hit,
		.profile_low_hit, .profile_high_hit, .area_passed, .rel_ref_reached,
		.point_skipped, .sensor_error, .overrange, .overload_cond,
		.zero_over_limit, .card_error, .autosave_busy, .panel_edit_req,
		.peak_low, .peak_pass, .peak_high, .profile_low, .profile_pass,
		.profile_high, .complete, .overload, .load_healthy,
		.displacement_healthy, .card_healthy, .heartbeat, .zero_offset,
		.displacement, .hold_section, .sampling, .discard, .panel_edit_ok,
		.backlight, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	msio_ctrl_model ctrl (.sys_clk, .complete, .judge({peak_low, peak_pass,
		peak_high, profile_low, profile_pass, profile_high}), .seen, .res,
		.fail);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic chk_v(input logic [31:0] g, x, input string s);
		num_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, s);
		end
	endtask : chk_v

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic tmo(input string s);
		chk_v(32'h0, 32'h1, s);
		report_and_stop();
	endtask : tmo

	// A read carries {mask, expected}; a write carries data in the low half.
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [63:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d[31:0];
		reg_wr <= w;
		reg_rd <= !w;
		if (!w) rq.push_back(d);
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask : bus

	task automatic noise();
		forever begin
			@(posedge sys_clk);
			{overload_cond, sensor_error, overrange, zero_over_limit,
				card_error, point_skipped, panel_lock, panel_edit_req,
				backlight_in, level_crossed} <= 10'($urandom);
		end
	endtask : noise

	always @(posedge sys_clk) begin
		if (rdp === 1'b1) begin
			m = rq.pop_front();
			chk_v(reg_rdata & m[63:32], m[31:0], "read");
		end
		rdp = reg_rd;
		if (seen === 1'b1) begin
			j = jq.pop_front();
			chk_v(32'(res), 32'(j), "judgment");
			chk_v(32'(fail), 32'(!j[4]), "verdict");
		end
	end

	task automatic meas(input logic [6:0] r, input bit rst);
		int i;
		logic [3:0] h0;
		start_in <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk_v(32'(complete), 32'h0, "complete");
		start_in <= 1'b0;
		for (i = 0; i < 40 && sampling !== 1'b1; i++) @(posedge sys_clk);
		if (i == 40) tmo("sampling");
		h0 = hold_section;
		{peak_judged, hold_done, peak_low_hit, peak_high_hit,
			profile_low_hit, profile_high_hit, area_passed,
			section_adv} <= {r, 1'b1};
		@(posedge sys_clk);
		{peak_judged, hold_done, peak_low_hit, peak_high_hit,
			profile_low_hit, profile_high_hit, area_passed} <= 7'h00;
		repeat (5) @(posedge sys_clk);
		section_adv <= 1'b0;
		chk_v(32'(hold_section), 32'(h0 + 4'h1), "section");
		if (rst) begin
			reset_in <= 1'b1;
			for (i = 0; i < 10 && discard !== 1'b1; i++) @(posedge sys_clk);
			if (i == 10) tmo("discard");
			repeat (4) @(posedge sys_clk);
			reset_in <= 1'b0;
			repeat (30) @(posedge sys_clk);
			chk_v(32'(complete), 32'h0, "aborted");
			chk_v(32'({peak_low, peak_high, profile_low, profile_high}),
				32'h0, "limits cleared");
		end else begin
			jq.push_back({r[4], r[6] & r[5] & !r[4] & !r[3], r[3], r[2],
				r[0] & !r[2] & !r[1] & !rel, r[1]});
			stop_in <= 1'b1;
			repeat (4) @(posedge sys_clk);
			stop_in <= 1'b0;
			for (i = 0; i < 60 && complete !== 1'b1; i++) @(posedge sys_clk);
			if (i == 60) tmo("complete");
		end
		bus(1'b0, `MSIO_ADDR_STATUS, {32'h117,
			23'h0, !rst & r[5], 3'h0, !rst & r[6], 4'h0});
	endtask : meas

	initial begin
		void'($urandom(44232));
		{zero_req, displacement_preset, start_in, stop_in, section_adv,
			reset_in, panel_lock, backlight_in, disp_pulse, level_crossed,
			stop_cond, hold_done, peak_judged, peak_low_hit, peak_high_hit,
			profile_low_hit, profile_high_hit, area_passed, rel_ref_reached,
			point_skipped, sensor_error, overrange, overload_cond,
			zero_over_limit, card_error, autosave_busy, panel_edit_req,
			reg_wr, reg_rd} = '0;
		load_value = 16'h0000;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reset = 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		fork
			noise();
		join_none
		@(posedge sys_clk);
		chk_v(32'(zero_offset), 32'h0, "offset");
		bus(1'b0, `MSIO_ADDR_STATUS, {32'h7, 32'h0});
		bus(1'b1, 4'h2, 64'hFFFFFFFF);
		bus(1'b0, 4'h2, {32'hFFFFFFFF, 32'h0});
		bus(1'b1, `MSIO_ADDR_CTRL, 64'h12);
		bus(1'b1, `MSIO_ADDR_PRESET, 64'h1234);
		load_value <= 16'($urandom);
		{zero_req, displacement_preset} <= 2'b11;
		repeat (6) @(posedge sys_clk);
		chk_v(32'(zero_offset), 32'(load_value), "zero");
		chk_v(32'(displacement), 32'h1234, "preset");
		chk_v(32'(displacement_healthy), 32'h0, "dh");
		{zero_req, displacement_preset} <= 2'b00;
		for (k = 0; k < 8; k++) begin
			if (k == 6) begin
				bus(1'b1, `MSIO_ADDR_CTRL, 64'h17);
				rel = 1'b1;
			end
			meas((k == 0) ? 7'h61 : 7'($urandom), k == 5);
		end
		report_and_stop();
	end
endmodule : measurement_sequence_io_tb
